// ==== uls_line_status.sv ====
// uls_line_status: line status register of a byte-wide serial port.
// assumes: receiver, transmitter, baud generator and data FIFOs live elsewhere
// on clk_i; only the raw receive pin arrives from outside the clock domain.

`timescale 1ns/1ps
`default_nettype none

module uls_line_status #(
    parameter int DEPTH = uls_pkg::FIFO_DEPTH
) (
    input  wire logic                       clk_i,
    input  wire logic                       reset_n_i,
    // host byte port
    input  wire logic [uls_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                       rd_i,
    input  wire logic                       wr_i,
    input  wire logic                       dlab_i,
    output logic      [uls_pkg::DATA_W-1:0] rdata_o,
    // configuration from neighbouring registers
    input  wire logic                       fifo_mode_i,
    input  wire logic [1:0]                 word_len_i,
    input  wire logic                       stop_sel_i,
    input  wire logic                       parity_en_i,
    input  wire logic                       ier_rls_i,
    input  wire logic                       ier_thre_i,
    input  wire logic                       mcr_out2_i,
    // receiver side
    input  wire logic                       rx_pin_i,
    input  wire logic                       ovs_tick_i,
    input  wire logic                       rx_char_done_i,
    input  wire logic                       rx_parity_err_i,
    input  wire logic                       rx_stop_bit_i,
    output logic                            rx_push_o,
    // transmitter side
    input  wire logic                       tx_load_i,
    input  wire logic                       tx_shift_busy_i,
    output logic                            tx_avail_o,
    output logic                            irq_o
);
    import uls_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("DEPTH must be a power of two, at least 2");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host access decode

    wire data_sel   = (addr_i == OFS_DATA) && !dlab_i;
    wire stat_rd    = rd_i && (addr_i == OFS_LINE_STAT);
    // writes to the status offset decode to nothing at all
    wire rbr_rd     = rd_i && data_sel;
    wire thr_wr     = wr_i && data_sel;

    ////////////////////////////////////////////////////////////////////////////
    // receive pin synchroniser and break detector

    logic                  rx_meta_reg;
    logic                  rx_sync_reg;
    logic [CHAR_CNT_W-1:0] low_cnt_reg;
    logic [CHAR_CNT_W-1:0] low_cnt_next;
    logic                  brk_armed_reg;

    function automatic logic [CHAR_CNT_W-1:0] char_ticks(
        input logic [1:0] wl,
        input logic       stp,
        input logic       par
    );
        int bits;
        int stop16;
        bits   = 1 + MIN_DATA_BITS + int'(wl) + int'(par);
        stop16 = !stp ? OVS : ((wl == 2'h0) ? OVS + OVS_HALF : 2 * OVS);
        return CHAR_CNT_W'(bits * OVS + stop16);
    endfunction

    wire [CHAR_CNT_W-1:0] char_len = char_ticks(word_len_i, stop_sel_i, parity_en_i);
    wire                  line_low = !rx_sync_reg;
    wire                  cnt_sat  = (low_cnt_reg == {CHAR_CNT_W{1'b1}});
    // longer than a whole character, so strictly beyond the count
    wire                  brk_det  = line_low && brk_armed_reg
                                     && (low_cnt_reg > char_len);

    always_comb begin
        low_cnt_next = low_cnt_reg;
        if (!line_low) begin
            low_cnt_next = '0;
        end else if (ovs_tick_i && !cnt_sat) begin
            low_cnt_next = low_cnt_reg + CHAR_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_meta_reg   <= 1'b1;
            rx_sync_reg   <= 1'b1;
            low_cnt_reg   <= '0;
            brk_armed_reg <= 1'b1;
        end else begin
            rx_meta_reg   <= rx_pin_i;
            rx_sync_reg   <= rx_meta_reg;
            low_cnt_reg   <= low_cnt_next;
            // one break report per low stretch; rearm on idle line
            brk_armed_reg <= line_low ? (brk_armed_reg && !brk_det) : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive occupancy and per-character error tags

    logic [CNT_W-1:0]  rx_cnt_reg;
    logic [CNT_W-1:0]  rx_cnt_next;
    logic [PTR_W-1:0]  wr_ptr_reg;
    logic [PTR_W-1:0]  rd_ptr_reg;
    logic [TAG_W-1:0]  tag_mem [DEPTH];
    logic              brk_pend_reg;
    logic              head_seen_reg;

    wire rx_full   = fifo_mode_i ? (rx_cnt_reg == CNT_W'(DEPTH)) : 1'b0;
    wire rx_empty  = (rx_cnt_reg == '0);
    // a full FIFO drops the fresh character; it stays in the shifter
    assign rx_push_o = rx_char_done_i && !rx_full;
    wire rx_pop    = rbr_rd && !rx_empty;

    wire             pe_new  = parity_en_i && rx_parity_err_i;
    wire             fe_new  = !rx_stop_bit_i;
    wire             bi_new  = brk_pend_reg || brk_det;
    wire [TAG_W-1:0] new_tag = {bi_new, fe_new, pe_new};
    wire [TAG_W-1:0] head_tag = tag_mem[rd_ptr_reg];

    always_comb begin
        rx_cnt_next = rx_cnt_reg;
        if (!fifo_mode_i) begin
            // character mode holds one buffered byte
            if (rx_push_o) begin
                rx_cnt_next = CNT_W'(1);
            end else if (rx_pop) begin
                rx_cnt_next = '0;
            end
        end else if (rx_push_o && !rx_pop) begin
            rx_cnt_next = rx_cnt_reg + CNT_W'(1);
        end else if (rx_pop && !rx_push_o) begin
            rx_cnt_next = rx_cnt_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_cnt_reg <= '0;
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            rx_cnt_reg <= rx_cnt_next;
            if (!fifo_mode_i) begin
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
            end else begin
                if (rx_push_o) begin
                    wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
                end
                if (rx_pop) begin
                    rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rx_push_o && fifo_mode_i) begin
            tag_mem[wr_ptr_reg] <= new_tag;
        end
    end

    // break seen while a character is still assembling rides with that character
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            brk_pend_reg <= 1'b0;
        end else if (rx_char_done_i || !fifo_mode_i) begin
            // character mode reports a break at once; holding it would tag a later byte
            brk_pend_reg <= 1'b0;
        end else if (brk_det) begin
            brk_pend_reg <= 1'b1;
        end
    end

    // head tag is reported once per character at the head
    wire head_show = fifo_mode_i && !rx_empty && !head_seen_reg;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            head_seen_reg <= 1'b0;
        end else if (rx_pop || !fifo_mode_i) begin
            head_seen_reg <= 1'b0;
        end else if (head_show) begin
            head_seen_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky error flags: a new event wins over a status read clear

    logic oe_reg;
    logic pe_reg;
    logic fe_reg;
    logic bi_reg;
    logic ferr_reg;

    wire chr_push = !fifo_mode_i && rx_push_o;
    wire chr_oe   = chr_push && !rx_empty && !rx_pop;
    wire fifo_oe  = fifo_mode_i && rx_char_done_i && rx_full;
    wire oe_set   = chr_oe || fifo_oe;

    wire pe_set   = (chr_push && pe_new)
                    || (head_show && head_tag[TAG_PE]);
    wire fe_set   = (chr_push && fe_new)
                    || (head_show && head_tag[TAG_FE]);
    wire bi_set   = (!fifo_mode_i && brk_det)
                    || (head_show && head_tag[TAG_BI]);
    wire ferr_set = fifo_mode_i && rx_push_o && (|new_tag);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            oe_reg   <= 1'b0;
            pe_reg   <= 1'b0;
            fe_reg   <= 1'b0;
            bi_reg   <= 1'b0;
            ferr_reg <= 1'b0;
        end else begin
            oe_reg   <= oe_set   || (oe_reg && !stat_rd);
            pe_reg   <= pe_set   || (pe_reg && !stat_rd);
            fe_reg   <= fe_set   || (fe_reg && !stat_rd);
            bi_reg   <= bi_set   || (bi_reg && !stat_rd);
            ferr_reg <= ferr_set || (ferr_reg && !stat_rd);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit holding occupancy

    logic [CNT_W-1:0] tx_cnt_reg;
    logic [CNT_W-1:0] tx_cnt_next;

    wire [CNT_W-1:0] tx_cap  = fifo_mode_i ? CNT_W'(DEPTH) : CNT_W'(1);
    wire             tx_full = (tx_cnt_reg >= tx_cap);
    wire             tx_take = thr_wr && !tx_full;
    wire             tx_give = tx_load_i && (tx_cnt_reg != '0);

    always_comb begin
        tx_cnt_next = tx_cnt_reg;
        if (tx_take && !tx_give) begin
            tx_cnt_next = tx_cnt_reg + CNT_W'(1);
        end else if (tx_give && !tx_take) begin
            tx_cnt_next = tx_cnt_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_cnt_reg <= '0;
        end else begin
            tx_cnt_reg <= tx_cnt_next;
        end
    end

    assign tx_avail_o = (tx_cnt_reg != '0);

    ////////////////////////////////////////////////////////////////////////////
    // status assembly, read port and interrupt

    // status reads touch none of these three
    wire thre = (tx_cnt_reg == '0);
    wire temt = thre && !tx_shift_busy_i;
    wire dr   = !rx_empty;

    wire [DATA_W-1:0] line_status;
    assign line_status[BIT_DR]       = dr;
    assign line_status[BIT_OE]       = oe_reg;
    assign line_status[BIT_PE]       = pe_reg;
    assign line_status[BIT_FE]       = fe_reg;
    assign line_status[BIT_BI]       = bi_reg;
    assign line_status[BIT_THRE]     = thre;
    assign line_status[BIT_TEMT]     = temt;
    assign line_status[BIT_FIFO_ERR] = fifo_mode_i && ferr_reg;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= LINE_STAT_RST;
        end else if (stat_rd) begin
            rdata_o <= line_status;
        end
    end

    wire rls_irq  = ier_rls_i && (oe_reg || pe_reg || fe_reg || bi_reg);
    wire thre_irq = ier_thre_i && thre;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= mcr_out2_i && (rls_irq || thre_irq);
        end
    end

endmodule

`default_nettype wire

// ==== uls_pkg.sv ====
// uls_pkg: constants for the serial port line status logic.
// assumes: one 250 MHz core clock; host reaches the port by direct byte offsets.

package uls_pkg;

    localparam int          ADDR_W        = 3;
    localparam int          DATA_W        = 8;

    // direct byte offsets
    localparam logic [2:0]  OFS_DATA      = 3'h0;
    localparam logic [2:0]  OFS_LINE_STAT = 3'h5;

    // status bit positions
    localparam int          BIT_DR        = 0;
    localparam int          BIT_OE        = 1;
    localparam int          BIT_PE        = 2;
    localparam int          BIT_FE        = 3;
    localparam int          BIT_BI        = 4;
    localparam int          BIT_THRE      = 5;
    localparam int          BIT_TEMT      = 6;
    localparam int          BIT_FIFO_ERR  = 7;

    localparam logic [7:0]  LINE_STAT_RST = 8'hC0;

    // per-character error tag layout
    localparam int          TAG_W         = 3;
    localparam int          TAG_PE        = 0;
    localparam int          TAG_FE        = 1;
    localparam int          TAG_BI        = 2;

    // character time in oversampling ticks
    localparam int          OVS           = 16;
    localparam int          OVS_HALF      = 8;
    localparam int          MIN_DATA_BITS = 5;
    localparam int          CHAR_CNT_W    = 8;

    localparam int          FIFO_DEPTH    = 16;

endpackage

// ==== uls_line_status_sva.sv ====
// uls_line_status_sva: port checker for the line status block.
// assumes: bound onto uls_line_status, one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module uls_line_status_sva (
    input wire logic                       clk_i,
    input wire logic                       reset_n_i,
    input wire logic [uls_pkg::ADDR_W-1:0] addr_i,
    input wire logic                       rd_i,
    input wire logic                       wr_i,
    input wire logic                       dlab_i,
    input wire logic [uls_pkg::DATA_W-1:0] rdata_o,
    input wire logic                       fifo_mode_i,
    input wire logic                       ier_thre_i,
    input wire logic                       mcr_out2_i,
    input wire logic                       rx_char_done_i,
    input wire logic                       rx_push_o,
    input wire logic                       tx_load_i,
    input wire logic                       tx_avail_o,
    input wire logic                       irq_o
);
    import uls_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire stat_rd = rd_i && addr_i == OFS_LINE_STAT;
    wire data_wr = wr_i && addr_i == OFS_DATA && !dlab_i;
    ////////////////////////////////////////////////////////////////////////
    property p_hold; !$past(stat_rd) |-> $stable(rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("status byte moved without a read");
    property p_temt; $past(stat_rd) |-> !rdata_o[BIT_TEMT] || rdata_o[BIT_THRE]; endproperty
    a_temt: assert property (p_temt) else $error("idle set with holding full");
    property p_char7; stat_rd && !fifo_mode_i |=> !rdata_o[BIT_FIFO_ERR]; endproperty
    a_char7: assert property (p_char7) else $error("bit 7 set in character mode");
    property p_gate; !$past(mcr_out2_i) |-> !irq_o; endproperty
    a_gate: assert property (p_gate) else $error("interrupt passed while gated");
    property p_thre; mcr_out2_i && ier_thre_i && !tx_avail_o |=> irq_o; endproperty
    a_thre: assert property (p_thre) else $error("no interrupt on holding empty");
    property p_push; rx_char_done_i && !fifo_mode_i |-> rx_push_o; endproperty
    a_push: assert property (p_push) else $error("character not stored");
    property p_nopush; !rx_char_done_i |-> !rx_push_o; endproperty
    a_nopush: assert property (p_nopush) else $error("store without a character");
    property p_avail; data_wr && !tx_load_i |=> tx_avail_o; endproperty
    a_avail: assert property (p_avail) else $error("write left holding empty");
endmodule
bind uls_line_status uls_line_status_sva sva_u (
    .clk_i, .reset_n_i, .addr_i, .rd_i, .wr_i, .dlab_i, .rdata_o, .fifo_mode_i,
    .ier_thre_i, .mcr_out2_i, .rx_char_done_i, .rx_push_o, .tx_load_i, .tx_avail_o, .irq_o
);
`default_nettype wire

// ==== uls_line_far.sv ====
// uls_line_far: line-side partner: remote sender events and transmit drain.
// assumes: the bench calls send_char and hold_low; clk_i is the core clock.
`timescale 1ns/1ps
`default_nettype none
module uls_line_far (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic tx_avail_i,
    input  wire logic stall_i,
    output logic      rx_pin_o,
    output logic      ovs_tick_o,
    output logic      char_done_o,
    output logic      par_err_o,
    output logic      stop_o,
    output logic      tx_load_o,
    output logic      tx_busy_o
);
    logic [1:0] div_reg;
    logic [4:0] busy_reg;
    initial begin
        rx_pin_o    = 1'b1;
        char_done_o = 1'b0;
        par_err_o   = 1'b0;
        stop_o      = 1'b1;
    end
    // 16x tick every fourth core cycle keeps break runs short
    assign ovs_tick_o = div_reg == 2'h0;
    assign tx_busy_o  = busy_reg != 5'h00 || tx_load_o;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_reg   <= 2'h0;
            busy_reg  <= 5'h00;
            tx_load_o <= 1'b0;
        end else begin
            div_reg   <= div_reg + 2'h1;
            tx_load_o <= tx_avail_i && !tx_busy_o && !stall_i;
            if (tx_load_o)
                busy_reg <= 5'h14;
            else if (busy_reg != 5'h00)
                busy_reg <= busy_reg - 5'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic send_char(input logic pe, input logic fe);
        @(posedge clk_i);
        char_done_o <= 1'b1;
        par_err_o   <= pe;
        stop_o      <= !fe;
        @(posedge clk_i);
        // qualifiers are only valid with the pulse; stale values are inverted
        char_done_o <= 1'b0;
        par_err_o   <= !pe;
        stop_o      <= fe;
    endtask
    task automatic hold_low(input int n);
        @(posedge clk_i);
        rx_pin_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rx_pin_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== uls_line_status_tb.sv ====
// uls_line_status_tb: self-checking bench for the line status block.
// assumes: partner uls_line_far on the line side, checker bound separately.
`timescale 1ns/1ps
`default_nettype none
module uls_line_status_tb;
    import uls_pkg::*;
    localparam int DEP = 4;
    logic       clk_i, reset_n_i, rd_i, wr_i, fifo_mode_i, ier_rls_i, ier_thre_i;
    logic       mcr_out2_i, rx_pin_i, ovs_tick_i, rx_char_done_i, rx_parity_err_i;
    logic       rx_stop_bit_i, rx_push_o, tx_load_i, tx_shift_busy_i, tx_avail_o;
    logic       irq_o, stall, dlab_i, parity_en_i;
    logic [2:0] addr_i;
    logic [7:0] rdata_o;
    int         error_cnt, n_checks;
    uls_line_status #(.DEPTH(DEP)) dut_u (
        .clk_i, .reset_n_i, .addr_i, .rd_i, .wr_i, .dlab_i, .rdata_o, .fifo_mode_i,
        .word_len_i(2'h3), .stop_sel_i(1'b0), .parity_en_i, .ier_rls_i, .ier_thre_i,
        .mcr_out2_i, .rx_pin_i, .ovs_tick_i, .rx_char_done_i, .rx_parity_err_i,
        .rx_stop_bit_i, .rx_push_o, .tx_load_i, .tx_shift_busy_i, .tx_avail_o, .irq_o
    );
    uls_line_far far_u (
        .clk_i, .reset_n_i, .tx_avail_i(tx_avail_o), .stall_i(stall), .rx_pin_o(rx_pin_i),
        .ovs_tick_o(ovs_tick_i), .char_done_o(rx_char_done_i), .par_err_o(rx_parity_err_i),
        .stop_o(rx_stop_bit_i), .tx_load_o(tx_load_i), .tx_busy_o(tx_shift_busy_i)
    );
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(input logic [2:0] a, input logic w);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= !w;
        wr_i   <= w;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        wr_i   <= 1'b0;
    endtask
    // status answer lands on the edge that takes the read
    task automatic stat(input logic [7:0] exp);
        acc(OFS_LINE_STAT, 1'b0);
        #1 chk("line_status", rdata_o, exp);
    endtask
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge clk_i);
        #1 chk("irq", {7'h00, irq_o}, {7'h00, exp});
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n_i, rd_i, wr_i, fifo_mode_i, ier_thre_i} = 5'h00;
        {ier_rls_i, mcr_out2_i, stall} = 3'h7;
        {dlab_i, parity_en_i} = 2'h1;
        addr_i    = 3'h0;
        error_cnt = 0;
        n_checks  = 0;
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1 chk("reset", rdata_o, LINE_STAT_RST);
        stat(8'h60);
        acc(OFS_LINE_STAT, 1'b1);
        stat(8'h60);
        far_u.send_char(1'b0, 1'b0);
        stat(8'h61);
        stat(8'h61);
        acc(OFS_DATA, 1'b0);
        stat(8'h60);
        far_u.send_char(1'b1, 1'b1);
        irq_is(1'b1);
        @(posedge clk_i) mcr_out2_i <= 1'b0;
        irq_is(1'b0);
        stat(8'h6D);
        stat(8'h61);
        far_u.send_char(1'b0, 1'b0);
        stat(8'h63);
        // divisor latch selected: offset 0 read must not drain the buffer
        @(posedge clk_i) dlab_i <= 1'b1;
        acc(OFS_DATA, 1'b0);
        stat(8'h61);
        @(posedge clk_i) {dlab_i, parity_en_i} <= 2'h0;
        far_u.send_char(1'b1, 1'b0);
        stat(8'h63);
        acc(OFS_DATA, 1'b0);
        stat(8'h60);
        @(posedge clk_i) parity_en_i <= 1'b1;
        @(posedge clk_i) mcr_out2_i <= 1'b1;
        @(posedge clk_i) ier_thre_i <= 1'b1;
        irq_is(1'b1);
        acc(OFS_DATA, 1'b1);
        stat(8'h00);
        irq_is(1'b0);
        @(posedge clk_i) stall <= 1'b0;
        repeat (4) @(posedge clk_i);
        stat(8'h20);
        repeat (30) @(posedge clk_i);
        stat(8'h60);
        @(posedge clk_i) ier_thre_i <= 1'b0;
        // 8 data + parity: a full character is 176 ticks, 704 cycles
        far_u.hold_low(600);
        repeat (4) @(posedge clk_i);
        stat(8'h60);
        far_u.hold_low(760);
        repeat (4) @(posedge clk_i);
        stat(8'h70);
        stat(8'h60);
        @(posedge clk_i) fifo_mode_i <= 1'b1;
        stat(8'h60);
        far_u.send_char(1'b0, 1'b0);
        far_u.send_char(1'b0, 1'b1);
        stat(8'hE1);
        stat(8'h61);
        acc(OFS_DATA, 1'b0);
        repeat (2) @(posedge clk_i);
        stat(8'h69);
        acc(OFS_DATA, 1'b0);
        stat(8'h60);
        for (int i = 0; i < DEP; i++) begin
            far_u.send_char(1'b0, 1'b0);
        end
        stat(8'h61);
        far_u.send_char(1'b0, 1'b0);
        stat(8'h63);
        for (int i = 0; i < DEP; i++) begin
            acc(OFS_DATA, 1'b0);
        end
        stat(8'h60);
        @(posedge clk_i) stall <= 1'b1;
        acc(OFS_DATA, 1'b1);
        acc(OFS_DATA, 1'b1);
        stat(8'h00);
        @(posedge clk_i) stall <= 1'b0;
        repeat (60) @(posedge clk_i);
        stat(8'h60);
        results;
    end
    initial begin
        #100000;
        error_cnt++;
        results;
    end
endmodule
`default_nettype wire
